// ### csr_pkg.sv
// Shared constants and types for the charger setpoint register bank.
package csr_pkg;
   localparam logic [7:0]  REG_CC_LO   = 8'h02;
   localparam logic [7:0]  REG_CC_HI   = 8'h03;
   localparam logic [7:0]  REG_CV_LO   = 8'h04;
   localparam logic [7:0]  REG_CV_HI   = 8'h05;
   localparam logic [7:0]  REG_RV_LO   = 8'h06;
   localparam logic [7:0]  REG_RV_HI   = 8'h07;
   // Field bits held in each byte of a pair; low-byte bits sit at the top of the byte.
   localparam int          CC_HI_W     = 5;
   localparam int          CC_LO_W     = 2;
   localparam int          CV_HI_W     = 7;
   localparam int          CV_LO_W     = 5;
   localparam int          RV_HI_W     = 6;
   localparam int          RV_LO_W     = 6;
   localparam int          BYTE_W      = 8;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   // Setpoint codes in 8 mV units: 3000 mV, 20800 mV, 1280 mV offset.
   localparam logic [12:0] V_MIN_CODE  = 13'h0177;
   localparam logic [12:0] V_MAX_CODE  = 13'h0A28;
   localparam logic [12:0] RV_OFFSET   = 13'h00A0;
   // Current clamps in 64 mA units: 384 mA and 2 A rounded down.
   localparam logic [6:0]  CC_PRE_MAX  = 7'h06;
   localparam logic [6:0]  CC_1S_MAX   = 7'h1F;
   // Cell-count strap codes and the default charge voltage for each (4.2 V per cell).
   localparam logic [1:0]  CELL_1S     = 2'h0;
   localparam logic [1:0]  CELL_2S     = 2'h1;
   localparam logic [1:0]  CELL_3S     = 2'h2;
   localparam logic [11:0] CV_DEF_1S   = 12'h020D;
   localparam logic [11:0] CV_DEF_2S   = 12'h041A;
   localparam logic [11:0] CV_DEF_3S   = 12'h0627;
   localparam logic [11:0] CV_DEF_4S   = 12'h0834;
   // Watchdog timing: printed periods in seconds, counted in 1 ms ticks.
   localparam logic [1:0]  WDT_OFF     = 2'h0;
   localparam logic [1:0]  WDT_5S      = 2'h1;
   localparam logic [1:0]  WDT_88S     = 2'h2;
   localparam int unsigned CLK_NS      = 40;
   localparam int unsigned NS_PER_MS   = 1_000_000;
   localparam int unsigned MS_PER_S    = 1000;
   localparam int unsigned WDT_TICK_MS = 1;
   localparam int unsigned WDT_5S_S    = 5;
   localparam int unsigned WDT_88S_S   = 88;
   localparam int unsigned WDT_175S_S  = 175;
   localparam int unsigned WDT_TICK_CYC_DEF = WDT_TICK_MS * NS_PER_MS / CLK_NS;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_TX, ST_TX, ST_ACK_RX} csr_i2c_st_t;

   function automatic logic [11:0] csr_cv_default(input logic [1:0] cells);
      case (cells)
         CELL_1S: return CV_DEF_1S;
         CELL_2S: return CV_DEF_2S;
         CELL_3S: return CV_DEF_3S;
         default: return CV_DEF_4S;
      endcase
   endfunction : csr_cv_default
endpackage : csr_pkg

// ### csr_wdt_if.sv
// Watchdog connection between the register bank and its timer.
`timescale 1ns/1ps
`default_nettype none
interface csr_wdt_if;
   logic [1:0] period;
   logic       kick;
   logic       expire;
   modport bank  (output period, output kick, input expire);
   modport timer (input period, input kick, output expire);
endinterface : csr_wdt_if
`default_nettype wire

// ### csr_watchdog.sv
// Watchdog timer that expires unless the charge current is rewritten in time.
`timescale 1ns/1ps
`default_nettype none
module csr_watchdog #(
   parameter int unsigned TICK_CYCLES = 25000,
   parameter int unsigned T5_TICKS    = 5000,
   parameter int unsigned T88_TICKS   = 88000,
   parameter int unsigned T175_TICKS  = 175000
) (
   input wire logic clk_sys,
   input wire logic rst,
   csr_wdt_if.timer wdt
);
   import csr_pkg::*;
   typedef struct packed {
      logic [31:0] pre;
      logic [31:0] ticks;
      logic        expire;
   } csr_wdt_st_t;
   csr_wdt_st_t q;
   csr_wdt_st_t next_q;
   logic [31:0] limit;

   always_comb begin
      next_q = q;
      next_q.expire = 1'b0;
      unique case (wdt.period)
         WDT_5S:  limit = T5_TICKS;
         WDT_88S: limit = T88_TICKS;
         default: limit = T175_TICKS;
      endcase
      if (rst) begin
         next_q = '0;
      end else if (wdt.kick || wdt.period == WDT_OFF) begin
         next_q.pre = '0;
         next_q.ticks = '0;
      end else if (q.pre == TICK_CYCLES - 1) begin
         next_q.pre = '0;
         if (q.ticks == limit - 1) begin
            next_q.ticks = '0;
            next_q.expire = 1'b1;
         end else begin
            next_q.ticks = q.ticks + 1;
         end
      end else begin
         next_q.pre = q.pre + 1;
      end
   end

   always_ff @(posedge clk_sys) begin
      q <= next_q;
   end

   assign wdt.expire = q.expire;
endmodule : csr_watchdog
`default_nettype wire

// ### csr_range_chk.sv
// Window check of a voltage setpoint code against the accepted range.
`timescale 1ns/1ps
`default_nettype none
module csr_range_chk (
   input  wire logic [12:0] code,
   output logic             in_range
);
   import csr_pkg::*;
   assign in_range = (code >= V_MIN_CODE) && (code <= V_MAX_CODE);
endmodule : csr_range_chk
`default_nettype wire

// ### csr_setpoint_regs.sv
// Charger setpoint register bank with its two-wire serial register port.
`timescale 1ns/1ps
`default_nettype none
module csr_setpoint_regs #(
   parameter logic [6:0]  I2C_ADDR        = 7'h09,
   parameter int unsigned WDT_TICK_CYCLES = csr_pkg::WDT_TICK_CYC_DEF,
   parameter int unsigned WDT_5S_TICKS    = csr_pkg::WDT_5S_S * csr_pkg::MS_PER_S / csr_pkg::WDT_TICK_MS,
   parameter int unsigned WDT_88S_TICKS   = csr_pkg::WDT_88S_S * csr_pkg::MS_PER_S / csr_pkg::WDT_TICK_MS,
   parameter int unsigned WDT_175S_TICKS  = csr_pkg::WDT_175S_S * csr_pkg::MS_PER_S / csr_pkg::WDT_TICK_MS
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [1:0]  cell_count_config_pin,
   input  wire logic        adapter_removed,
   input  wire logic        cell_removed,
   input  wire logic        precharge_active,
   input  wire logic        vbat_below_vsysmin,
   input  wire logic        low_range_select,
   input  wire logic [1:0]  watchdog_period_select,
   output logic             charge_enable,
   output logic [6:0]       charge_current_code,
   output logic [11:0]      charge_voltage_code,
   output logic [12:0]      reverse_discharge_voltage_code
);
   import csr_pkg::*;

   typedef struct packed {
      csr_i2c_st_t st;
      logic        addr_ph;
      logic        rw;
      logic        ptr_ok;
      logic        nack;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        scl_q;
      logic        sda_q;
      logic        sda_oe;
      logic        sda_out;
      logic        wr;
      logic [7:0]  wa;
      logic [7:0]  wd;
      logic [6:0]  cc;
      logic [11:0] cv;
      logic [11:0] rv;
      logic [2:0]  pv;
      logic [7:0]  p_cc;
      logic [7:0]  p_cv;
      logic [7:0]  p_rv;
      logic        kick;
      logic        en;
      logic [6:0]  cc_app;
      logic [12:0] rv_app;
   } csr_st_t;

   csr_st_t     q;
   csr_st_t     next_q;
   logic [7:0]  rd_byte;
   logic [7:0]  cc_lo;
   logic [7:0]  cv_lo;
   logic [7:0]  rv_lo;
   logic [15:0] cv_pair;
   logic [12:0] cv_cand;
   logic [12:0] rv_cand;
   logic        cv_ok;
   logic        rv_ok;
   logic        start_c;
   logic        stop_c;
   logic        rise;
   logic        fall;
   logic [12:0] rv_off;

   csr_wdt_if wdt ();

   csr_watchdog #(
      .TICK_CYCLES (WDT_TICK_CYCLES),
      .T5_TICKS    (WDT_5S_TICKS),
      .T88_TICKS   (WDT_88S_TICKS),
      .T175_TICKS  (WDT_175S_TICKS)
   ) u_wdt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .wdt     (wdt)
   );

   assign wdt.period = watchdog_period_select;
   assign wdt.kick   = q.kick;

   // Committed low-byte images, used for readback and, for the voltage pair, for a high-only write.
   // current and voltage byte layout
   assign cc_lo = BYTE_W'(q.cc[CC_LO_W-1:0]) << (BYTE_W - CC_LO_W);
   assign cv_lo = BYTE_W'(q.cv[CV_LO_W-1:0]) << (BYTE_W - CV_LO_W);
   assign rv_lo = BYTE_W'(q.rv[RV_LO_W-1:0]) << (BYTE_W - RV_LO_W);

   assign cv_pair = {q.wd, q.pv[1] ? q.p_cv : cv_lo};
   assign cv_cand = {1'b0, q.wd[CV_HI_W-1:0], cv_pair[BYTE_W-1 -: CV_LO_W]};
   assign rv_off  = low_range_select ? '0 : RV_OFFSET;
   assign rv_cand = {1'b0, q.wd[RV_HI_W-1:0], q.pv[2] ? q.p_rv[BYTE_W-1 -: RV_LO_W] : q.rv[RV_LO_W-1:0]} + rv_off;

   csr_range_chk u_cv_chk (
      .code     (cv_cand),
      .in_range (cv_ok)
   );
   csr_range_chk u_rv_chk (
      .code     (rv_cand),
      .in_range (rv_ok)
   );

   always_comb begin
      unique case (q.ptr)
         REG_CC_LO: rd_byte = cc_lo;
         REG_CC_HI: rd_byte = BYTE_W'(q.cc >> CC_LO_W);
         REG_CV_LO: rd_byte = cv_lo;
         REG_CV_HI: rd_byte = BYTE_W'(q.cv >> CV_LO_W);
         REG_RV_LO: rd_byte = rv_lo;
         REG_RV_HI: rd_byte = BYTE_W'(q.rv >> RV_LO_W);
         default:   rd_byte = '0;
      endcase
   end

   assign start_c = scl && q.scl_q && q.sda_q && !sda_in;
   assign stop_c  = scl && q.scl_q && !q.sda_q && sda_in;
   assign rise    = scl && !q.scl_q;
   assign fall    = !scl && q.scl_q;

   always_comb begin
      next_q = q;
      next_q.scl_q = scl;
      next_q.sda_q = sda_in;
      next_q.wr = 1'b0;
      next_q.kick = 1'b0;
      // Serial port: bytes shift in on rising clock, SDA changes on falling clock.
      if (start_c) begin
         next_q.st = ST_RX;
         next_q.addr_ph = 1'b1;
         next_q.cnt = '0;
         next_q.sda_oe = 1'b0;
      end else if (stop_c) begin
         next_q.st = ST_IDLE;
         next_q.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (rise) begin
                  next_q.sh = {q.sh[6:0], sda_in};
                  next_q.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt == BITS_PER_BYTE) begin
                  next_q.cnt = '0;
                  next_q.st = ST_ACK_TX;
                  next_q.sda_oe = 1'b1;
                  if (q.addr_ph) begin
                     next_q.rw = q.sh[0];
                     next_q.ptr_ok = 1'b0;
                     if (q.sh[7:1] != I2C_ADDR) begin
                        next_q.st = ST_IDLE;
                        next_q.sda_oe = 1'b0;
                     end
                  end else if (!q.ptr_ok) begin
                     next_q.ptr = q.sh;
                     next_q.ptr_ok = 1'b1;
                  end else begin
                     next_q.wr = 1'b1;
                     next_q.wa = q.ptr;
                     next_q.wd = q.sh;
                     next_q.ptr = q.ptr + 8'h01;
                  end
               end
            end
            ST_ACK_TX: begin
               if (fall) begin
                  next_q.addr_ph = 1'b0;
                  next_q.sda_oe = 1'b0;
                  next_q.st = ST_RX;
                  if (q.rw) begin
                     next_q.sh = rd_byte;
                     next_q.ptr = q.ptr + 8'h01;
                     next_q.st = ST_TX;
                     next_q.sda_oe = !rd_byte[7];
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  next_q.cnt = q.cnt + 4'h1;
               end else if (fall) begin
                  if (q.cnt == BITS_PER_BYTE) begin
                     next_q.cnt = '0;
                     next_q.sda_oe = 1'b0;
                     next_q.st = ST_ACK_RX;
                  end else begin
                     next_q.sh = {q.sh[6:0], 1'b0};
                     next_q.sda_oe = !q.sh[6];
                  end
               end
            end
            ST_ACK_RX: begin
               if (rise) begin
                  next_q.nack = sda_in;
               end else if (fall) begin
                  if (q.nack) begin
                     next_q.st = ST_IDLE;
                  end else begin
                     next_q.sh = rd_byte;
                     next_q.ptr = q.ptr + 8'h01;
                     next_q.st = ST_TX;
                     next_q.sda_oe = !rd_byte[7];
                  end
               end
            end
         endcase
      end

      // Register writes land one cycle after the byte is acknowledged.
      if (q.wr) begin
         unique case (q.wa)
            REG_CC_LO: begin
               next_q.p_cc = q.wd;
               next_q.pv[0] = 1'b1;
            end
            REG_CC_HI: begin
               next_q.cc = {q.wd[CC_HI_W-1:0], q.pv[0] ? q.p_cc[BYTE_W-1 -: CC_LO_W] : q.cc[CC_LO_W-1:0]};
               next_q.pv[0] = 1'b0;
               next_q.kick = 1'b1;
            end
            REG_CV_LO: begin
               next_q.p_cv = q.wd;
               next_q.pv[1] = 1'b1;
            end
            REG_CV_HI: begin
               next_q.pv[1] = 1'b0;
               if (cv_pair == '0) begin
                  next_q.cc = '0;
                  next_q.cv = csr_cv_default(cell_count_config_pin);
               end else if (cv_ok) begin
                  next_q.cv = cv_cand[11:0];
               end
            end
            REG_RV_LO: begin
               next_q.p_rv = q.wd;
               next_q.pv[2] = 1'b1;
            end
            REG_RV_HI: begin
               next_q.pv[2] = 1'b0;
               if (rv_ok) begin
                  next_q.rv = rv_cand[11:0] - rv_off[11:0];
               end
            end
            default: begin
            end
         endcase
      end

      if (adapter_removed || cell_removed || wdt.expire) begin
         next_q.cc = '0;
      end

      next_q.en = (q.cc != '0);
      next_q.cc_app = q.cc;
      if (precharge_active && q.cc > CC_PRE_MAX) begin
         next_q.cc_app = CC_PRE_MAX;
      end else if (!precharge_active && cell_count_config_pin == CELL_1S && vbat_below_vsysmin
                   && q.cc > CC_1S_MAX) begin
         next_q.cc_app = CC_1S_MAX;
      end
      next_q.rv_app = {1'b0, q.rv} + rv_off;

      if (rst) begin
         next_q = '0;
         // Idle bus level, so no false edge is seen after reset.
         next_q.scl_q = 1'b1;
         next_q.sda_q = 1'b1;
         next_q.cv = csr_cv_default(cell_count_config_pin);
      end
   end

   always_ff @(posedge clk_sys) begin
      q <= next_q;
   end

   assign sda_out                        = q.sda_out;
   assign sda_oe                         = q.sda_oe;
   assign charge_enable                  = q.en;
   assign charge_current_code            = q.cc_app;
   assign charge_voltage_code            = q.cv;
   assign reverse_discharge_voltage_code = q.rv_app;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_zero_disables: assert property (q.cc == '0 |=> !charge_enable)
      else $error("charging enabled with zero target");
   chk_pre_clamp: assert property (precharge_active |=> charge_current_code <= CC_PRE_MAX)
      else $error("precharge current above clamp");
   chk_single_clamp: assert property (!precharge_active && cell_count_config_pin == CELL_1S
      && vbat_below_vsysmin |=> charge_current_code <= CC_1S_MAX)
      else $error("single cell current above clamp");
   chk_removal_clear: assert property (adapter_removed || cell_removed |=> q.cc == '0 ##1 !charge_enable)
      else $error("removal did not clear current");
   chk_cv_reject: assert property (q.wr && q.wa == REG_CV_HI && cv_pair != '0 && !cv_ok
      |=> $stable(q.cv))
      else $error("out of range voltage accepted");
   chk_cv_zero: assert property (q.wr && q.wa == REG_CV_HI && cv_pair == '0
      |=> q.cc == '0 && q.cv == csr_cv_default(cell_count_config_pin))
      else $error("zero write did not restore default");
   chk_rv_reject: assert property (q.wr && q.wa == REG_RV_HI && !rv_ok |=> $stable(q.rv))
      else $error("out of range reverse voltage accepted");
   chk_rv_offset: assert property ($stable(low_range_select) && $stable(q.rv) |=>
      reverse_discharge_voltage_code == {1'b0, $past(q.rv)} + ($past(low_range_select) ? 13'h0000 : RV_OFFSET))
      else $error("reverse voltage offset wrong");
   chk_wdt_clear: assert property (wdt.expire |=> q.cc == '0)
      else $error("watchdog expiry did not clear current");
   chk_pair_hold: assert property (q.wr && (q.wa == REG_CC_LO || q.wa == REG_CV_LO || q.wa == REG_RV_LO)
      && !adapter_removed && !cell_removed && !wdt.expire |=> $stable(q.cc) && $stable(q.cv) && $stable(q.rv))
      else $error("low byte write changed a setpoint");
   chk_reset_default: assert property ($past(rst) |-> q.cv == csr_cv_default($past(cell_count_config_pin)))
      else $error("charge voltage default not from strap");

   cov_cc_write: cover property (q.wr && q.wa == REG_CC_HI);
   cov_cv_accept: cover property (q.wr && q.wa == REG_CV_HI && cv_ok ##1 charge_voltage_code != '0);
   cov_read_byte: cover property (q.st == ST_TX && q.rw);
   cov_wdt_expire: cover property (wdt.expire);
endmodule : csr_setpoint_regs
`default_nettype wire

// ### csr_host_model.sv
// Behavioural host processor that drives the two-wire register port.
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      pull
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic half();
      repeat (5) @(negedge clk_sys);
   endtask : half
   // A released line during the high phase lets the device answer.
   task automatic bit_io(input logic b, output logic s);
      pull = ~b;
      half();
      scl = 1'b1;
      half();
      s = sda;
      scl = 1'b0;
   endtask : bit_io
   task automatic start();
      pull = 1'b0;
      half();
      scl = 1'b1;
      half();
      pull = 1'b1;
      half();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      pull = 1'b1;
      half();
      scl = 1'b1;
      half();
      pull = 1'b0;
      half();
   endtask : stop
   task automatic xfer(input logic [7:0] v, input logic last, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], r[i]);
      end
      bit_io(last, s);
      ack = ~s;
   endtask : xfer
   // Reserved bits are sent exactly as the caller supplies them.
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int n, output logic ok);
      logic [7:0] r;
      logic       k;
      start();
      xfer({a, 1'b0}, 1'b1, r, ok);
      xfer(p, 1'b1, r, k);
      for (int i = 0; i < n; i++) begin
         xfer(d[8*i+:8], 1'b1, r, k);
      end
      stop();
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
      logic [7:0] r;
      logic       k;
      start();
      xfer({a, 1'b0}, 1'b1, r, k);
      xfer(p, 1'b1, r, k);
      start();
      xfer({a, 1'b1}, 1'b1, r, k);
      for (int i = 0; i < 2; i++) begin
         xfer(8'hFF, i[0], r, k);
         d[8*i+:8] = r;
      end
      stop();
   endtask : rd
endmodule : csr_host_model
`default_nettype wire

// ### charger_setpoint_registers_tb_top.sv
// Self-checking bench for the charger setpoint register bank.
`timescale 1ns/1ps
`default_nettype none
module charger_setpoint_registers_tb_top;
   import csr_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        scl, pull, sda_out, sda_oe, sda, ok, en;
   logic [1:0]  cells = 2'h1;
   logic [1:0]  wsel = 2'h0;
   logic        ad_rm = 1'b0, cl_rm = 1'b0, pre = 1'b0, vlow = 1'b0, lrs = 1'b0;
   logic [6:0]  cc;
   logic [11:0] cv;
   logic [12:0] rv;
   logic [15:0] d;
   logic [6:0]  cc_tab [3] = '{7'h7F, 7'h01, 7'h5A};
   logic [11:0] cv_in [4] = '{12'h177, 12'hA28, 12'h176, 12'hA29};
   logic [11:0] cv_ex [4] = '{12'h177, 12'hA28, 12'hA28, 12'hA28};
   logic        rv_lr [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   logic [11:0] rv_f [5] = '{12'h100, 12'h176, 12'h176, 12'h989, 12'hA28};
   logic [12:0] rv_ex [5] = '{13'h01A0, 13'h0100, 13'h0216, 13'h0216, 13'h0A28};
   int          n_fail = 0;
   int          compares = 0;
   always #20 clk_sys = ~clk_sys;
   // Open-drain line with a pull-up: low when either party pulls.
   assign sda = ~pull & (~sda_oe | sda_out);
   csr_setpoint_regs #(.WDT_TICK_CYCLES(4), .WDT_5S_TICKS(3), .WDT_88S_TICKS(5), .WDT_175S_TICKS(7))
   u_csr_setpoint_regs (.clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .cell_count_config_pin(cells), .adapter_removed(ad_rm), .cell_removed(cl_rm),
      .precharge_active(pre), .vbat_below_vsysmin(vlow), .low_range_select(lrs),
      .watchdog_period_select(wsel), .charge_enable(en), .charge_current_code(cc),
      .charge_voltage_code(cv), .reverse_discharge_voltage_code(rv));
   csr_host_model u_csr_host_model (.clk_sys(clk_sys), .sda(sda), .scl(scl), .pull(pull));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic wait_n(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : wait_n
   task automatic wr(input logic [7:0] p, input logic [15:0] v, input int n);
      u_csr_host_model.wr(7'h09, p, v, n, ok);
   endtask : wr
   task automatic rd(input logic [7:0] p);
      u_csr_host_model.rd(7'h09, p, d);
   endtask : rd
   task automatic do_reset();
      rst = 1'b1;
      wait_n(20);
      rst = 1'b0;
      wait_n(2);
   endtask : do_reset
   initial begin
      // About 13,000 cycles of traffic are expected; this allows roughly twice that.
      #1_000_000;
      n_fail++;
      print_verdict();
   end
   initial begin
      do_reset();
      check(cv, CV_DEF_2S); // strap default
      check(rv, RV_OFFSET); // offset at reset
      rd(REG_CV_LO);
      check(d, {1'b0, CV_DEF_2S[11:5], CV_DEF_2S[4:0], 3'h0}); // voltage layout
      rd(REG_RV_LO);
      check(d, 16'h0000); // reverse reset value
      rd(8'h08);
      check(d, 16'h0000); // unmapped space reads zero
      $display("test reset finished");
      foreach (cc_tab[i]) begin
         wr(REG_CC_LO, {3'h0, cc_tab[i][6:2], cc_tab[i][1:0], 6'h00}, 2);
         check(cc, cc_tab[i]); // current code
         check(en, 1'b1); // charging on
         rd(REG_CC_LO);
         check(d, {3'h0, cc_tab[i][6:2], cc_tab[i][1:0], 6'h00}); // current layout
      end
      wr(REG_CC_LO, 16'h0000, 2);
      check(en, 1'b0); // zero disables charging
      wr(REG_CC_LO, 16'h1FC0, 2);
      pre = 1'b1;
      wait_n(3);
      check(cc, CC_PRE_MAX); // precharge clamp
      pre = 1'b0;
      vlow = 1'b1;
      wait_n(3);
      check(cc, 7'h7F); // no clamp above one cell
      vlow = 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(REG_CC_LO, 16'h1FC0, 2);
         ad_rm = (i == 0);
         cl_rm = (i == 1);
         wait_n(1);
         ad_rm = 1'b0;
         cl_rm = 1'b0;
         wait_n(3);
         check(cc, 7'h00); // removal clears current
      end
      $display("test current finished");
      foreach (cv_in[i]) begin
         wr(REG_CV_LO, {1'b0, cv_in[i][11:5], cv_in[i][4:0], 3'h0}, 2);
         check(cv, cv_ex[i]); // range window
      end
      wr(REG_CC_LO, 16'h0400, 2);
      wr(REG_CV_LO, 16'h0000, 2);
      check(cc, 7'h00); // zero write clears current
      check(cv, CV_DEF_2S); // zero write restores default
      $display("test voltage finished");
      foreach (rv_f[i]) begin
         lrs = rv_lr[i];
         wr(REG_RV_LO, {2'h0, rv_f[i][11:6], rv_f[i][5:0], 2'h0}, 2);
         check(rv, rv_ex[i]); // range and offset
      end
      rd(REG_RV_LO);
      check(d, {2'h0, rv_f[4][11:6], rv_f[4][5:0], 2'h0}); // reverse layout
      $display("test reverse finished");
      wr(REG_CC_LO, 16'h00C0, 1);
      check(cc, 7'h00); // low byte alone waits
      wr(REG_CC_HI, 16'h0001, 1);
      check(cc, 7'h07); // high byte commits pair
      $display("test pairing finished");
      for (int s = 1; s < 4; s++) begin
         wsel = s[1:0];
         wr(REG_CC_LO, 16'h0800, 2);
         if (s == 3) begin
            check(cc, 7'h20); // rewrite restarts timer
         end
         wait_n(40);
         check(cc, 7'h00); // expiry clears current
      end
      wsel = 2'h0;
      $display("test watchdog finished");
      cells = 2'h0;
      do_reset();
      check(cv, CV_DEF_1S); // one-cell default
      wr(REG_CC_LO, 16'h1FC0, 2);
      vlow = 1'b1;
      wait_n(3);
      check(cc, CC_1S_MAX); // one-cell low battery clamp
      pre = 1'b1;
      wait_n(3);
      check(cc, CC_PRE_MAX); // precharge wins
      cells = 2'h2;
      do_reset();
      check(cv, CV_DEF_3S); // three-cell default
      cells = 2'h3;
      do_reset();
      check(cv, CV_DEF_4S); // four-cell default
      $display("test one_cell finished");
      print_verdict();
   end
endmodule : charger_setpoint_registers_tb_top
`default_nettype wire
